// ===== shared/meas_act_pkg.sv
// Constants for the measurement activation scheduler
package meas_act_pkg;

  // Activation mode codes
  localparam logic [1:0] MODE_CONTINUOUS = 2'h0;
  localparam logic [1:0] MODE_POLL       = 2'h1;
  localparam logic [1:0] MODE_MASTER     = 2'h2;
  localparam logic [1:0] MODE_FOLLOWER   = 2'h3;
  localparam logic [1:0] MODE_RESET      = MODE_CONTINUOUS;

  // Phase configuration
  localparam logic [2:0] PHASE_MIN       = 3'h1;
  localparam logic [2:0] PHASE_MAX       = 3'h5;
  localparam logic [2:0] PHASE_RESET     = 3'h2;

  // Timer widths and reset values
  localparam int         TICK_W          = 32;
  localparam int         NOSYNC_W        = 32;
  localparam logic [31:0] INTERVAL_RESET = 32'h0000_0010;
  localparam logic [31:0] NOSYNC_RESET   = 32'h0000_0100;

  // Group size limits
  localparam int         GROUP_MIN       = 2;
  localparam int         GROUP_MAX       = 32;

  // Red/green flash half period in cycles, less one (toggles every FLASH_HALF + 1 cycles)
  localparam logic [7:0] FLASH_HALF      = 8'h80;

endpackage

// ===== rtl/measurement_activation_sync.sv
// Measurement activation scheduler with group timing and no-sync handling
`timescale 1ns/1ps

module measurement_activation_sync (
  // Clock and reset
  input  wire logic        sys_clk_i,
  input  wire logic        rstn_i,
  // Configuration
  input  wire logic [1:0]  mode_i,
  input  wire logic [2:0]  phase_cfg_i,
  input  wire logic [31:0] interval_i,
  input  wire logic [31:0] nosync_delay_i,
  // Serial link events
  input  wire logic        poll_i,
  input  wire logic        result_read_i,
  input  wire logic        sync_cmd_i,
  // Measurement process handshake
  input  wire logic        meas_done_i,
  input  wire logic [15:0] meas_dist_i,
  // Measurement control
  output logic             meas_start_o,
  output logic             meas_busy_o,
  output logic             out_update_o,
  output logic [15:0]      dist_stored_o,
  // Serial behaviour
  output logic             poll_reply_o,
  output logic [15:0]      reply_dist_o,
  output logic             sync_cmd_send_o,
  output logic             serial_normal_en_o,
  output logic             serial_diff_o,
  // Feature gating
  output logic             pushbutton_setup_en_o,
  output logic             majority_vote_filter_en_o,
  output logic             rate_filter_en_o,
  output logic             slow_fast_filter_en_o,
  output logic             nearest_of_batch_filter_en_o,
  output logic             farthest_of_batch_filter_en_o,
  // Loss of sync
  output logic             nosync_flash_o,
  output logic             nosync_out_o,
  output logic             nosync_timeout_o
);

  typedef enum logic [2:0] {
    ST_IDLE = 3'b001,
    ST_BUSY = 3'b010,
    ST_HALT = 3'b100
  } run_state_t;

  run_state_t  state_q;
  logic [31:0] tick_q;
  logic [2:0]  slot_q;
  logic [2:0]  phase_q;
  logic        pending_q;
  logic        fol_arm_q;
  logic [2:0]  fol_slot_q;
  logic [31:0] fol_tick_q;
  logic [31:0] nosync_q;
  logic        synced_q;
  logic [7:0]  flash_cnt_q;
  logic        start_d;
  logic        poll_ev;
  logic        is_grp;

  assign poll_ev = poll_i | result_read_i;
  assign is_grp  = (mode_i == meas_act_pkg::MODE_MASTER) |
                   (mode_i == meas_act_pkg::MODE_FOLLOWER);

  // Phase count clamps illegal settings to the default
  always_ff @(posedge sys_clk_i) begin
    if (!rstn_i) begin
      phase_q <= meas_act_pkg::PHASE_RESET;
    end else if (phase_cfg_i >= meas_act_pkg::PHASE_MIN &&
                 phase_cfg_i <= meas_act_pkg::PHASE_MAX) begin
      phase_q <= phase_cfg_i;
    end else begin
      phase_q <= meas_act_pkg::PHASE_RESET;
    end
  end

  // Interval tick and phase slot; master wraps over phase_q slots
  always_ff @(posedge sys_clk_i) begin
    if (!rstn_i) begin
      tick_q <= '0;
      slot_q <= meas_act_pkg::PHASE_MIN;
    end else if (tick_q + 32'h1 >= interval_i) begin
      tick_q <= '0;
      if (slot_q >= phase_q) begin
        slot_q <= meas_act_pkg::PHASE_MIN;
      end else begin
        slot_q <= slot_q + 3'h1;
      end
    end else begin
      tick_q <= tick_q + 32'h1;
    end
  end

  // Follower slot tracking, restarted by each master command
  always_ff @(posedge sys_clk_i) begin
    if (!rstn_i) begin
      fol_arm_q  <= 1'b0;
      fol_slot_q <= meas_act_pkg::PHASE_MIN;
      fol_tick_q <= '0;
    end else if (mode_i != meas_act_pkg::MODE_FOLLOWER) begin
      fol_arm_q <= 1'b0;
    end else if (sync_cmd_i) begin
      fol_arm_q  <= 1'b1;
      fol_slot_q <= meas_act_pkg::PHASE_MIN;
      fol_tick_q <= '0;
    end else if (fol_arm_q) begin
      if (fol_tick_q + 32'h1 >= interval_i) begin
        fol_tick_q <= '0;
        fol_slot_q <= fol_slot_q + 3'h1;
        // Past phase 5 no slot can match; wait for next command
        if (fol_slot_q >= meas_act_pkg::PHASE_MAX) begin
          fol_arm_q <= 1'b0;
        end
      end else begin
        fol_tick_q <= fol_tick_q + 32'h1;
      end
    end
  end

  // Start decision per mode
  always_comb begin
    start_d = 1'b0;
    unique case (mode_i)
      meas_act_pkg::MODE_CONTINUOUS: begin
        start_d = (tick_q == '0);
      end
      meas_act_pkg::MODE_POLL: begin
        start_d = (state_q != ST_BUSY) && (poll_ev || pending_q);
      end
      meas_act_pkg::MODE_MASTER: begin
        start_d = (tick_q == '0) &&
                  (slot_q == meas_act_pkg::PHASE_MIN);
      end
      meas_act_pkg::MODE_FOLLOWER: begin
        // Phase 1 starts on the command itself, so one-phase groups align
        // A fresh command restarts slots, so a too-high phase never fires
        start_d = (sync_cmd_i && phase_q == meas_act_pkg::PHASE_MIN) ||
          (synced_q && fol_arm_q && !sync_cmd_i &&
           fol_tick_q + 32'h1 >= interval_i &&
           fol_slot_q + 3'h1 == phase_q);
      end
    endcase
  end

  // Held poll while a process runs; set wins over clear
  always_ff @(posedge sys_clk_i) begin
    if (!rstn_i) begin
      pending_q <= 1'b0;
    end else if (mode_i != meas_act_pkg::MODE_POLL) begin
      pending_q <= 1'b0;
    end else if (poll_ev && state_q == ST_BUSY) begin
      pending_q <= 1'b1;
    end else if (start_d) begin
      pending_q <= 1'b0;
    end
  end

  // Process state; halt after poll completion
  always_ff @(posedge sys_clk_i) begin
    if (!rstn_i) begin
      state_q <= ST_IDLE;
    end else begin
      unique case (state_q)
        ST_IDLE, ST_HALT: begin
          if (start_d) begin
            state_q <= ST_BUSY;
          end
        end
        ST_BUSY: begin
          if (meas_done_i) begin
            state_q <= (mode_i == meas_act_pkg::MODE_POLL) ? ST_HALT
                                                          : ST_IDLE;
          end
        end
        default: state_q <= ST_IDLE;
      endcase
    end
  end

  // Start strobe and output update
  always_ff @(posedge sys_clk_i) begin
    if (!rstn_i) begin
      meas_start_o  <= 1'b0;
      meas_busy_o   <= 1'b0;
      out_update_o  <= 1'b0;
      dist_stored_o <= '0;
    end else begin
      // A start in busy is dropped in free-run modes; process outlasts it
      meas_start_o <= start_d && (state_q != ST_BUSY);
      meas_busy_o  <= (state_q == ST_BUSY) && !meas_done_i;
      out_update_o <= (state_q == ST_BUSY) && meas_done_i;
      if (state_q == ST_BUSY && meas_done_i) begin
        dist_stored_o <= meas_dist_i;
      end
    end
  end

  // Poll reply from stored value; group modes never answer
  always_ff @(posedge sys_clk_i) begin
    if (!rstn_i) begin
      poll_reply_o <= 1'b0;
      reply_dist_o <= '0;
    end else begin
      poll_reply_o <= poll_ev && !is_grp;
      if (poll_ev && !is_grp) begin
        reply_dist_o <= dist_stored_o;
      end
    end
  end

  // Serial link ownership and signalling
  always_ff @(posedge sys_clk_i) begin
    if (!rstn_i) begin
      sync_cmd_send_o    <= 1'b0;
      serial_normal_en_o <= 1'b1;
      serial_diff_o      <= 1'b0;
    end else begin
      sync_cmd_send_o    <= (mode_i == meas_act_pkg::MODE_MASTER) &&
                            start_d;
      serial_normal_en_o <= !is_grp;
      serial_diff_o      <= is_grp;
    end
  end

  // Feature gating per mode
  always_ff @(posedge sys_clk_i) begin
    if (!rstn_i) begin
      pushbutton_setup_en_o         <= 1'b1;
      majority_vote_filter_en_o     <= 1'b1;
      rate_filter_en_o              <= 1'b1;
      slow_fast_filter_en_o         <= 1'b1;
      nearest_of_batch_filter_en_o  <= 1'b1;
      farthest_of_batch_filter_en_o <= 1'b1;
    end else begin
      pushbutton_setup_en_o     <= mode_i != meas_act_pkg::MODE_POLL;
      majority_vote_filter_en_o <= mode_i != meas_act_pkg::MODE_POLL;
      rate_filter_en_o          <= mode_i != meas_act_pkg::MODE_POLL;
      slow_fast_filter_en_o     <= mode_i != meas_act_pkg::MODE_POLL;
      nearest_of_batch_filter_en_o  <= 1'b1;
      farthest_of_batch_filter_en_o <= 1'b1;
    end
  end

  // No-sync timer restarts on each command; flags clear on return
  always_ff @(posedge sys_clk_i) begin
    if (!rstn_i) begin
      nosync_q         <= '0;
      synced_q         <= 1'b1;
      nosync_out_o     <= 1'b0;
      nosync_timeout_o <= 1'b0;
    end else if (mode_i != meas_act_pkg::MODE_FOLLOWER || sync_cmd_i) begin
      nosync_q         <= '0;
      synced_q         <= 1'b1;
      nosync_out_o     <= 1'b0;
      nosync_timeout_o <= 1'b0;
    end else begin
      nosync_timeout_o <= 1'b0;
      if (nosync_q + 32'h1 == nosync_delay_i) begin
        nosync_q         <= nosync_q + 32'h1;
        synced_q         <= 1'b0;
        nosync_out_o     <= 1'b1;
        nosync_timeout_o <= 1'b1;
      end else if (synced_q) begin
        nosync_q <= nosync_q + 32'h1;
      end
    end
  end

  // Indicator flash while out of sync
  always_ff @(posedge sys_clk_i) begin
    if (!rstn_i) begin
      flash_cnt_q    <= '0;
      nosync_flash_o <= 1'b0;
    end else if (synced_q) begin
      flash_cnt_q    <= '0;
      nosync_flash_o <= 1'b0;
    end else if (flash_cnt_q == meas_act_pkg::FLASH_HALF) begin
      flash_cnt_q    <= '0;
      nosync_flash_o <= !nosync_flash_o;
    end else begin
      flash_cnt_q <= flash_cnt_q + 8'h1;
    end
  end

  a_start_pulse: assert property (
    @(posedge sys_clk_i) disable iff (!rstn_i)
    meas_start_o |=> !meas_start_o)
    else $error("start strobe longer than one cycle");
  // Gating lags the mode by one edge, so the edge after reset is skipped
  a_poll_filters: assert property (
    @(posedge sys_clk_i) disable iff (!rstn_i)
    $past(rstn_i) && $past(mode_i) == meas_act_pkg::MODE_POLL |->
      !majority_vote_filter_en_o && !pushbutton_setup_en_o &&
      !rate_filter_en_o && !slow_fast_filter_en_o &&
      nearest_of_batch_filter_en_o && farthest_of_batch_filter_en_o)
    else $error("filters enabled in poll mode");
  a_group_no_reply: assert property (
    @(posedge sys_clk_i) disable iff (!rstn_i)
    is_grp && $past(is_grp) |-> !poll_reply_o)
    else $error("group sensor answered a poll");
  a_reply_prior: assert property (
    @(posedge sys_clk_i) disable iff (!rstn_i)
    poll_ev && !is_grp |=> reply_dist_o == $past(dist_stored_o))
    else $error("reply not previous distance");
  a_serial_excl: assert property (
    @(posedge sys_clk_i) disable iff (!rstn_i)
    !(serial_normal_en_o && serial_diff_o))
    else $error("serial modes overlap");
  a_update_done: assert property (
    @(posedge sys_clk_i) disable iff (!rstn_i)
    state_q == ST_BUSY && meas_done_i |=> out_update_o &&
      dist_stored_o == $past(meas_dist_i))
    else $error("no update at process end");
  a_nosync_stop: assert property (
    @(posedge sys_clk_i) disable iff (!rstn_i)
    !synced_q && mode_i == meas_act_pkg::MODE_FOLLOWER && !sync_cmd_i
      |-> !start_d)
    else $error("follower measured without sync");
  a_no_busy_start: assert property (
    @(posedge sys_clk_i) disable iff (!rstn_i)
    state_q == ST_BUSY |=> !meas_start_o)
    else $error("start while process running");
  a_phase_range: assert property (
    @(posedge sys_clk_i) disable iff (!rstn_i)
    phase_q >= meas_act_pkg::PHASE_MIN && phase_q <= meas_act_pkg::PHASE_MAX)
    else $error("phase count out of range");

  c_poll_run: cover property (@(posedge sys_clk_i) disable iff (!rstn_i)
    mode_i == meas_act_pkg::MODE_POLL && poll_ev ##[1:50] out_update_o);
  c_poll_pend: cover property (@(posedge sys_clk_i) disable iff (!rstn_i)
    pending_q ##[1:50] meas_start_o);
  c_master_cmd: cover property (@(posedge sys_clk_i) disable iff (!rstn_i)
    sync_cmd_send_o);
  c_timeout: cover property (@(posedge sys_clk_i) disable iff (!rstn_i)
    nosync_timeout_o);

endmodule

// ===== sim/meas_proc_model.sv
// Measurement process model answering start strobes after a latency
`timescale 1ns/1ps
module meas_proc_model (
  // Clock
  input  wire logic        clk_i,
  // Process handshake
  input  wire logic        start_i,
  input  wire logic [7:0]  lat_i,
  input  wire logic [15:0] dist_i,
  output logic             done_o,
  output logic [15:0]      dist_o
);
  int cnt = 0;
  initial begin
    done_o = 1'b0;
    dist_o = 16'h0000;
  end
  // Distance is garbage outside done, never a stale hold
  always @(posedge clk_i) begin
    #1;
    done_o = 1'b0;
    dist_o = ~dist_o;
    if (start_i) begin
      cnt = lat_i;
    end else if (cnt > 1) begin
      cnt--;
    end else if (cnt == 1) begin
      cnt = 0;
      done_o = 1'b1;
      dist_o = dist_i;
    end
  end
endmodule

// ===== sim/measurement_activation_sync_test.sv
// Self-checking bench for the measurement activation scheduler
`timescale 1ns/1ps
module measurement_activation_sync_test;
  logic        sys_clk_i = 1'b0;
  logic        rstn_i = 1'b0;
  logic [1:0]  mode_i = 2'h0;
  logic [2:0]  phase_cfg_i = 3'h2;
  logic [31:0] interval_i = 32'h0000_0014;
  logic [31:0] nosync_delay_i = 32'h0000_00C8;
  logic        poll_i = 1'b0;
  logic        result_read_i = 1'b0;
  logic        sync_cmd_i = 1'b0;
  logic        meas_done_i;
  logic [15:0] meas_dist_i;
  logic        meas_start_o, meas_busy_o, out_update_o, poll_reply_o;
  logic [15:0] dist_stored_o, reply_dist_o, dist_v, last_dist;
  logic        sync_cmd_send_o, serial_normal_en_o, serial_diff_o;
  logic        pushbutton_setup_en_o, majority_vote_filter_en_o;
  logic        rate_filter_en_o, slow_fast_filter_en_o;
  logic        nearest_of_batch_filter_en_o, farthest_of_batch_filter_en_o;
  logic        nosync_flash_o, nosync_out_o, nosync_timeout_o;
  logic [7:0]  lat = 8'h04;
  integer      seed = 32'hD2E240F1;
  int          n_mismatch = 0, total_checks = 0, cyc = 0, last_st, last_to;
  int          n_st, n_up, n_done, exp_per, p, iv, sc, n_fl;

  always #2 sys_clk_i = ~sys_clk_i;

  measurement_activation_sync dut (
    .sys_clk_i                     (sys_clk_i),
    .rstn_i                        (rstn_i),
    .mode_i                        (mode_i),
    .phase_cfg_i                   (phase_cfg_i),
    .interval_i                    (interval_i),
    .nosync_delay_i                (nosync_delay_i),
    .poll_i                        (poll_i),
    .result_read_i                 (result_read_i),
    .sync_cmd_i                    (sync_cmd_i),
    .meas_done_i                   (meas_done_i),
    .meas_dist_i                   (meas_dist_i),
    .meas_start_o                  (meas_start_o),
    .meas_busy_o                   (meas_busy_o),
    .out_update_o                  (out_update_o),
    .dist_stored_o                 (dist_stored_o),
    .poll_reply_o                  (poll_reply_o),
    .reply_dist_o                  (reply_dist_o),
    .sync_cmd_send_o               (sync_cmd_send_o),
    .serial_normal_en_o            (serial_normal_en_o),
    .serial_diff_o                 (serial_diff_o),
    .pushbutton_setup_en_o         (pushbutton_setup_en_o),
    .majority_vote_filter_en_o     (majority_vote_filter_en_o),
    .rate_filter_en_o              (rate_filter_en_o),
    .slow_fast_filter_en_o         (slow_fast_filter_en_o),
    .nearest_of_batch_filter_en_o  (nearest_of_batch_filter_en_o),
    .farthest_of_batch_filter_en_o (farthest_of_batch_filter_en_o),
    .nosync_flash_o                (nosync_flash_o),
    .nosync_out_o                  (nosync_out_o),
    .nosync_timeout_o              (nosync_timeout_o)
  );
  meas_proc_model proc (.clk_i(sys_clk_i), .start_i(meas_start_o),
    .lat_i(lat), .dist_i(dist_v), .done_o(meas_done_i), .dist_o(meas_dist_i));

  task automatic chk(input logic [31:0] got, input logic [31:0] exp);
    total_checks++;
    if (got !== exp) begin
      n_mismatch++;
      $display("Error at %0t: got %0h expected %0h", $time, got, exp);
    end
  endtask
  task automatic tick(input int n);
    repeat (n) @(posedge sys_clk_i);
    #1;
  endtask
  task automatic do_reset(input int n);
    rstn_i = 1'b0;
    tick(n);
    rstn_i = 1'b1;
    {n_st, n_up, n_done, last_st, last_to, n_fl} = '0;
    last_dist = 16'h0000;
  endtask
  // Drives one poll pulse, checks the one-cycle reply
  task automatic poll(input bit rd, input logic rep, input logic [15:0] v);
    if (rd) result_read_i = 1'b1;
    else poll_i = 1'b1;
    tick(1);
    poll_i = 1'b0;
    result_read_i = 1'b0;
    chk(poll_reply_o, rep);
    if (rep) chk(reply_dist_o, v);
  endtask
  task automatic wait_upd;
    int k = 0;
    while (out_update_o !== 1'b1 && k < 600) begin
      tick(1);
      k++;
    end
    chk(k < 600, 1);
    tick(2);
  endtask
  function automatic int rnd(input int lo, input int span);
    return lo + (($random(seed) & 32'h7FFF_FFFF) % span);
  endfunction
  task automatic give_verdict;
    $display("Checks %0d mismatches %0d", total_checks, n_mismatch);
    if (n_mismatch == 0 && total_checks > 0) $display("RESULT: PASS");
    else $display("RESULT: FAIL");
    $finish;
  endtask

  // Values sampled before the edge's own updates land
  always @(posedge sys_clk_i) begin
    cyc++;
    if (rstn_i && meas_done_i) begin
      n_done++;
      last_dist = meas_dist_i;
    end
    if (rstn_i && out_update_o) n_up++;
    if (rstn_i && nosync_timeout_o) last_to = cyc;
    if (rstn_i && nosync_flash_o) n_fl++;
    if (rstn_i && meas_start_o) begin
      if (exp_per != 0 && last_st != 0) begin
        chk(cyc - last_st, exp_per);
      end
      if (mode_i == meas_act_pkg::MODE_MASTER) begin
        chk(sync_cmd_send_o, 1);
      end
      last_st = cyc;
      n_st++;
    end
  end

  initial begin
    #200000;
    n_mismatch++;
    give_verdict();
  end

  initial begin
    // Continuous mode at a random interval, set up before the first reset
    iv = rnd(10, 16);
    interval_i = iv;
    exp_per = iv;
    dist_v = 16'($random(seed));
    do_reset(20);
    chk({serial_normal_en_o, serial_diff_o}, 2'h2);
    chk({pushbutton_setup_en_o, majority_vote_filter_en_o}, 2'h3);
    wait_upd();
    chk(dist_stored_o, last_dist);
    poll(0, 1, last_dist);
    tick(6 * iv);
    chk(n_up, n_done);
    chk(n_st >= 6, 1);
    $display("test continuous done");
    // Poll mode: deferred start, prior distance in reply
    mode_i = meas_act_pkg::MODE_POLL;
    exp_per = 0;
    lat = 8'h1E;
    do_reset(2);
    tick(50);
    chk(n_st, 0);
    chk({pushbutton_setup_en_o, majority_vote_filter_en_o,
      rate_filter_en_o, slow_fast_filter_en_o,
      nearest_of_batch_filter_en_o, farthest_of_batch_filter_en_o},
      6'h03);
    dist_v = 16'($random(seed));
    poll(0, 1, 16'h0000);
    chk(meas_start_o, 1);
    tick(5);
    poll(1, 1, 16'h0000);
    chk(meas_start_o, 0);
    chk(meas_busy_o, 1);
    wait_upd();
    chk(n_st, 2);
    dist_v = 16'($random(seed));
    wait_upd();
    tick(100);
    chk(n_st, 2);
    chk(n_up, 2);
    chk(meas_busy_o, 0);
    poll(0, 1, last_dist);
    $display("test poll done");
    // Master at random phase count
    p = rnd(1, 5);
    iv = rnd(10, 16);
    mode_i = meas_act_pkg::MODE_MASTER;
    phase_cfg_i = 3'(p);
    interval_i = iv;
    exp_per = p * iv;
    lat = 8'h04;
    do_reset(2);
    tick(4 * p * iv);
    poll(0, 0, 16'h0000);
    chk({serial_normal_en_o, serial_diff_o}, 2'h1);
    chk(n_st >= 3, 1);
    chk(n_up, n_done);
    $display("test master done");
    // Follower phase offsets and loss of timing
    mode_i = meas_act_pkg::MODE_FOLLOWER;
    exp_per = 0;
    repeat (3) begin
      p = rnd(1, 5);
      iv = rnd(10, 16);
      phase_cfg_i = 3'(p);
      interval_i = iv;
      nosync_delay_i = rnd(200, 64);
      do_reset(2);
      // Phase setting lands one edge after reset; command waits for it
      tick(1);
      sync_cmd_i = 1'b1;
      tick(1);
      sc = cyc;
      sync_cmd_i = 1'b0;
      tick(p * iv + 5);
      chk(last_st - sc, 1 + (p - 1) * iv);
      tick(nosync_delay_i);
      chk(last_to - sc, nosync_delay_i + 1);
      chk(nosync_out_o, 1);
      chk(n_st, 1);
      chk(serial_diff_o, 1);
      tick(130);
      chk(n_fl > 0, 1);
      sync_cmd_i = 1'b1;
      tick(1);
      sync_cmd_i = 1'b0;
      tick(1);
      chk(nosync_out_o, 0);
      chk(nosync_flash_o, 0);
      tick(p * iv + 5);
      chk(n_st, 2);
    end
    $display("test follower done");
    // Phase 4 follower under a three-phase master: commands every 3 slots
    phase_cfg_i = 3'h4;
    interval_i = 32'h0000_000A;
    do_reset(2);
    tick(1);
    repeat (4) begin
      sync_cmd_i = 1'b1;
      tick(1);
      sync_cmd_i = 1'b0;
      tick(29);
    end
    chk(n_st, 0);
    $display("test follower phase limit done");
    give_verdict();
  end
endmodule
